// ==== inc/mbts_defs.svh ====
// timing constants and field widths for the muxed bus sequencer
`ifndef MBTS_DEFS_SVH
`define MBTS_DEFS_SVH
`define MBTS_MEM_CYCLES 3
`define MBTS_IO_CYCLES 4
`define MBTS_ACK_CYCLES 5
`define MBTS_ACK_AUTO_WAITS 2
`define MBTS_INTERRUPT_RETURN_FETCH_IDLE 3
`define MBTS_REFRESH_MARK_N_BITS 10
`define MBTS_KIND_W 3
`endif

// ==== inc/mbts_pkg.sv ====
// types for the muxed bus sequencer
package mbts_pkg;
   typedef enum logic [2:0] {
      MBTS_K_MEM, MBTS_K_INTERRUPT_RETURN_FETCH, MBTS_K_IOP, MBTS_K_HALT,
      MBTS_K_IO, MBTS_K_ACK, MBTS_K_REFRESH_MARK_N
   } mbts_kind_t;
   typedef enum logic [2:0] {
      MBTS_S_IDLE, MBTS_S_ADDR, MBTS_S_AUTO, MBTS_S_DATA, MBTS_S_WAIT, MBTS_S_LAST, MBTS_S_GAP
   } mbts_state_t;
endpackage

// ==== design/mbts_reset_sync.sv ====
// two-flop reset release
`timescale 1ns/100ps
`default_nettype none
module mbts_reset_sync (
   input wire logic clk,
   input wire logic rst_n,
   output logic rst_sync_n
);
   typedef struct packed {
      logic s1;
      logic s2;
   } mbts_rs_t;
   mbts_rs_t r_r;
   mbts_rs_t r_nxt;
   always_comb begin
      r_nxt = r_r;
      r_nxt.s1 = 1'b1;
      r_nxt.s2 = r_r.s1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end
   assign rst_sync_n = r_r.s2;
endmodule
`default_nettype wire

// ==== design/mbts_seq.sv ====
// muxed address/data bus transaction sequencer
//
// Behaviour
// [RQ1] address strobe pulse starts each transaction, address valid
// [RQ2] store strobe only while write data driven
// [RQ3] release data lines before read strobe
// [RQ4] capture read data before read strobe rises
// [RQ5] stall request sampled at data point, adds cycles
// [RQ6] stall request must be synchronous to clock
// [RQ7] automatic waits precede first stall sample
// [RQ8] memory transaction three cycles without waits
// [RQ9] memory read strobe and enable timing
// [RQ10] data capture ends memory request and enable
// [RQ11] return fetch: two reads with first-cycle flag
// [RQ12] three idle cycles after each return read
// [RQ13] internal op and halt move no data
// [RQ14] ignore stall in internal op and halt
// [RQ15] halt indicator held until acknowledge or reset
// [RQ16] other transactions allowed while halted
// [RQ17] io transaction at least four cycles
// [RQ18] io strobes in cycle two, data timing
// [RQ19] acknowledge five cycles, two automatic waits
// [RQ20] vector captured before io request rises
// [RQ21] acknowledge samples stall at two points
// [RQ22] refresh puts counter out with memory request
//
// one bus cycle is one clk period; half-cycle events move to the next edge
`timescale 1ns/100ps
`default_nettype none
`include "mbts_defs.svh"
module mbts_seq #(
   parameter int AUTO_W = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [2:0] req_kind,
   input wire logic req_write,
   input wire logic [23:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic [AUTO_W-1:0] auto_waits,
   input wire logic stall_n,
   input wire logic [7:0] ad_in,
   output logic req_ready,
   output logic [7:0] rdata,
   output logic rdata_valid,
   output logic [7:0] ad_out,
   output logic ad_oe_n,
   output logic [15:0] addr_hi,
   output logic address_strobe_n,
   output logic memory_request_n,
   output logic io_request_n,
   output logic first_cycle_flag_n,
   output logic read_n,
   output logic store_n,
   output logic out_enable_n,
   output logic inbound_enable_n,
   output logic refresh_mark_n,
   output logic halt_n
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      mbts_pkg::mbts_state_t st;
      mbts_pkg::mbts_kind_t kind;
      logic wr;
      logic second;
      logic [7:0] wdata;
      logic [AUTO_W-1:0] autos;
      logic [3:0] cnt;
      logic [`MBTS_REFRESH_MARK_N_BITS-1:0] refresh_mark_n_ctr;
      logic ready;
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] ad;
      logic ad_oe_n;
      logic [15:0] ahi;
      logic as_n;
      logic memory_request_n_n;
      logic io_request_n_n;
      logic m1_n;
      logic rd_n;
      logic wr_n;
      logic oe_n;
      logic ie_n;
      logic rf_n;
      logic halt_n;
   } mbts_seq_t;

   mbts_seq_t r_r;
   mbts_seq_t r_nxt;
   logic rst_sync_n;

   mbts_reset_sync u_rst (
      .clk(clk),
      .rst_n(rst_n),
      .rst_sync_n(rst_sync_n)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic is_read_kind(input mbts_pkg::mbts_kind_t k, input logic w);
      is_read_kind = (k == mbts_pkg::MBTS_K_MEM || k == mbts_pkg::MBTS_K_IO) ? !w
         : (k == mbts_pkg::MBTS_K_INTERRUPT_RETURN_FETCH || k == mbts_pkg::MBTS_K_ACK);
   endfunction

   function automatic logic stall_ignored(input mbts_pkg::mbts_kind_t k);
      stall_ignored = (k == mbts_pkg::MBTS_K_IOP || k == mbts_pkg::MBTS_K_HALT
         || k == mbts_pkg::MBTS_K_REFRESH_MARK_N);
   endfunction

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   always_comb begin
      r_nxt = r_r;
      r_nxt.rvalid = 1'b0;
      case (r_r.st)
         mbts_pkg::MBTS_S_IDLE: begin
            r_nxt.ready = 1'b1;
            if (req_valid && r_r.ready) begin
               r_nxt.ready = 1'b0;
               r_nxt.kind = mbts_pkg::mbts_kind_t'(req_kind);
               r_nxt.wr = req_write;
               r_nxt.wdata = req_wdata;
               r_nxt.second = 1'b0;
               r_nxt.autos = auto_waits;
               r_nxt.st = mbts_pkg::MBTS_S_ADDR;
               // address phase: strobe low, drive address, out enable [RQ1]
               r_nxt.as_n = 1'b0;
               r_nxt.oe_n = 1'b0;
               r_nxt.ad_oe_n = 1'b0;
               r_nxt.ahi = req_addr[23:8];
               r_nxt.ad = req_addr[7:0];
               if (req_kind == 3'(mbts_pkg::MBTS_K_REFRESH_MARK_N)) begin
                  // refresh counter on low lines [RQ22]
                  r_nxt.ad = r_r.refresh_mark_n_ctr[7:0];
                  r_nxt.ahi = {14'h0000, r_r.refresh_mark_n_ctr[9:8]};
               end
               if (req_kind == 3'(mbts_pkg::MBTS_K_ACK)) begin
                  r_nxt.ad_oe_n = 1'b1; // no address [RQ1]
                  r_nxt.m1_n = 1'b0;
               end
               if (req_kind == 3'(mbts_pkg::MBTS_K_INTERRUPT_RETURN_FETCH)) begin
                  r_nxt.m1_n = 1'b0; // early in cycle one [RQ11]
               end
            end
         end
         mbts_pkg::MBTS_S_ADDR: begin
            // strobe rises, address already valid [RQ1]
            r_nxt.as_n = 1'b1;
            r_nxt.cnt = 4'h2;
            case (r_r.kind)
               mbts_pkg::MBTS_K_MEM, mbts_pkg::MBTS_K_INTERRUPT_RETURN_FETCH: begin
                  r_nxt.memory_request_n_n = 1'b0; // [RQ9]
                  if (is_read_kind(r_r.kind, r_r.wr)) begin
                     r_nxt.ad_oe_n = 1'b1; // release before read strobe [RQ3]
                     r_nxt.oe_n = 1'b1;
                     r_nxt.rd_n = 1'b0;
                     r_nxt.ie_n = 1'b0; // [RQ4] [RQ9]
                  end else begin
                     r_nxt.ad = r_r.wdata;
                     r_nxt.wr_n = 1'b0; // data valid, out enable held [RQ2]
                  end
               end
               mbts_pkg::MBTS_K_HALT: begin
                  r_nxt.memory_request_n_n = 1'b0;
                  r_nxt.halt_n = 1'b0; // [RQ15]
                  r_nxt.oe_n = 1'b1;
                  r_nxt.ad_oe_n = 1'b1; // no data moved [RQ13]
               end
               mbts_pkg::MBTS_K_IOP: begin
                  r_nxt.oe_n = 1'b1;
                  r_nxt.ad_oe_n = 1'b1; // no request, no strobes [RQ13]
               end
               mbts_pkg::MBTS_K_REFRESH_MARK_N: begin
                  r_nxt.memory_request_n_n = 1'b0;
                  r_nxt.rf_n = 1'b0; // never read strobe [RQ22]
                  r_nxt.oe_n = 1'b1;
                  r_nxt.ad_oe_n = 1'b1;
               end
               mbts_pkg::MBTS_K_IO: begin
                  r_nxt.cnt = 4'h3; // four cycles [RQ17]
                  r_nxt.io_request_n_n = 1'b0; // [RQ18]
                  if (r_r.wr) begin
                     r_nxt.ad = r_r.wdata;
                     r_nxt.wr_n = 1'b0; // [RQ2] [RQ18]
                  end else begin
                     r_nxt.ad_oe_n = 1'b1; // [RQ3]
                     r_nxt.oe_n = 1'b1;
                     r_nxt.rd_n = 1'b0;
                     r_nxt.ie_n = 1'b0; // [RQ18]
                  end
               end
               default: begin
                  // acknowledge: two automatic waits first [RQ19]
                  r_nxt.oe_n = 1'b1;
                  r_nxt.cnt = 4'(`MBTS_ACK_AUTO_WAITS);
               end
            endcase
            r_nxt.st = (r_r.kind == mbts_pkg::MBTS_K_ACK) ? mbts_pkg::MBTS_S_AUTO
               : mbts_pkg::MBTS_S_DATA;
         end
         mbts_pkg::MBTS_S_AUTO: begin
            // fixed settle cycles, then stall sample before io request [RQ19] [RQ21]
            if (r_r.cnt > 4'h1) begin
               r_nxt.cnt = r_r.cnt - 4'h1;
            end else if (stall_n) begin
               r_nxt.io_request_n_n = 1'b0;
               r_nxt.rd_n = 1'b0;
               r_nxt.ie_n = 1'b0; // vector driven by interrupter [RQ20]
               r_nxt.cnt = 4'h2;
               r_nxt.st = mbts_pkg::MBTS_S_DATA;
            end
         end
         mbts_pkg::MBTS_S_DATA: begin
            if (r_r.cnt > 4'h2) begin
               r_nxt.cnt = r_r.cnt - 4'h1;
            end else if (r_r.autos != '0) begin
               // programmed waits precede stall sample [RQ7]
               r_nxt.autos = r_r.autos - 1'b1;
            end else if (!stall_n && !stall_ignored(r_r.kind)) begin
               r_nxt.st = mbts_pkg::MBTS_S_DATA; // extra cycle, resample [RQ5] [RQ6] [RQ14] [RQ21]
            end else begin
               r_nxt.st = mbts_pkg::MBTS_S_LAST;
               if (is_read_kind(r_r.kind, r_r.wr)) begin
                  // capture data at the sample point [RQ4] [RQ20]
                  r_nxt.rdata = ad_in;
                  r_nxt.rvalid = 1'b1;
               end
               if (r_r.kind != mbts_pkg::MBTS_K_INTERRUPT_RETURN_FETCH) begin
                  r_nxt.memory_request_n_n = 1'b1; // [RQ10]
                  r_nxt.ie_n = 1'b1;
               end
            end
         end
         mbts_pkg::MBTS_S_LAST: begin
            // last cycle ends; strobes and flags released, halt kept unless acknowledge [RQ8] [RQ11]
            r_nxt.memory_request_n_n = 1'b1;
            r_nxt.io_request_n_n = 1'b1;
            r_nxt.rd_n = 1'b1;
            r_nxt.wr_n = 1'b1;
            r_nxt.ie_n = 1'b1;
            r_nxt.oe_n = 1'b1;
            r_nxt.rf_n = 1'b1;
            r_nxt.ad_oe_n = 1'b1;
            r_nxt.m1_n = 1'b1;
            if (r_r.kind == mbts_pkg::MBTS_K_ACK) begin
               r_nxt.halt_n = 1'b1; // acknowledge ends halt [RQ15]
            end
            if (r_r.kind == mbts_pkg::MBTS_K_REFRESH_MARK_N) begin
               r_nxt.refresh_mark_n_ctr = r_r.refresh_mark_n_ctr + 1'b1;
            end
            r_nxt.cnt = 4'(`MBTS_INTERRUPT_RETURN_FETCH_IDLE);
            // refresh or other work may follow at once, even halted [RQ16] [RQ22]
            r_nxt.st = (r_r.kind == mbts_pkg::MBTS_K_INTERRUPT_RETURN_FETCH) ? mbts_pkg::MBTS_S_GAP
               : mbts_pkg::MBTS_S_IDLE;
            r_nxt.ready = (r_r.kind != mbts_pkg::MBTS_K_INTERRUPT_RETURN_FETCH);
         end
         mbts_pkg::MBTS_S_GAP: begin
            // idle cycles after each return read [RQ12]
            if (r_r.cnt > 4'h1) begin
               r_nxt.cnt = r_r.cnt - 4'h1;
            end else if (!r_r.second) begin
               // second read of the pair [RQ11]
               r_nxt.second = 1'b1;
               r_nxt.autos = auto_waits;
               r_nxt.as_n = 1'b0;
               r_nxt.oe_n = 1'b0;
               r_nxt.ad_oe_n = 1'b0;
               r_nxt.m1_n = 1'b0;
               r_nxt.st = mbts_pkg::MBTS_S_ADDR;
            end else begin
               r_nxt.ready = 1'b1;
               r_nxt.st = mbts_pkg::MBTS_S_IDLE;
            end
         end
         default: begin
            r_nxt.st = mbts_pkg::MBTS_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         r_r <= '0;
         r_r.st <= mbts_pkg::MBTS_S_IDLE;
         r_r.kind <= mbts_pkg::MBTS_K_MEM;
         r_r.ad_oe_n <= 1'b1;
         r_r.as_n <= 1'b1;
         r_r.memory_request_n_n <= 1'b1;
         r_r.io_request_n_n <= 1'b1;
         r_r.m1_n <= 1'b1;
         r_r.rd_n <= 1'b1;
         r_r.wr_n <= 1'b1;
         r_r.oe_n <= 1'b1;
         r_r.ie_n <= 1'b1;
         r_r.rf_n <= 1'b1;
         r_r.halt_n <= 1'b1; // reset ends halt [RQ15]
      end else begin
         r_r <= r_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign req_ready = r_r.ready;
   assign rdata = r_r.rdata;
   assign rdata_valid = r_r.rvalid;
   assign ad_out = r_r.ad;
   assign ad_oe_n = r_r.ad_oe_n;
   assign addr_hi = r_r.ahi;
   assign address_strobe_n = r_r.as_n;
   assign memory_request_n = r_r.memory_request_n_n;
   assign io_request_n = r_r.io_request_n_n;
   assign first_cycle_flag_n = r_r.m1_n;
   assign read_n = r_r.rd_n;
   assign store_n = r_r.wr_n;
   assign out_enable_n = r_r.oe_n;
   assign inbound_enable_n = r_r.ie_n;
   assign refresh_mark_n = r_r.rf_n;
   assign halt_n = r_r.halt_n;
endmodule
`default_nettype wire

// ==== bench/mbts_seq_checker.sv ====
// port assertions for the muxed bus sequencer
`timescale 1ns/100ps
`default_nettype none
module mbts_seq_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic rdata_valid,
   input wire logic ad_oe_n,
   input wire logic address_strobe_n,
   input wire logic memory_request_n,
   input wire logic io_request_n,
   input wire logic first_cycle_flag_n,
   input wire logic read_n,
   input wire logic store_n,
   input wire logic out_enable_n,
   input wire logic inbound_enable_n,
   input wire logic refresh_mark_n,
   input wire logic halt_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_take_starts_strobe: assert property (req_valid && req_ready |=> $fell(address_strobe_n))
      else $error("no address strobe after request");
   a_strobe_with_oe: assert property ($fell(address_strobe_n) |-> !out_enable_n)
      else $error("output enable missing at strobe");
   a_busy_in_txn: assert property (!address_strobe_n |-> !req_ready)
      else $error("ready during address phase");
   a_store_drives_bus: assert property (!store_n |-> !ad_oe_n && !out_enable_n)
      else $error("store strobe without driven data");
   a_read_bus_free: assert property (!read_n |-> ad_oe_n)
      else $error("bus driven during read");
   a_capture_then_rise: assert property (rdata_valid && !read_n |=> read_n)
      else $error("read strobe not raised after capture");
   a_memory_request_n_ends_capture: assert property (
      rdata_valid && first_cycle_flag_n && io_request_n |-> memory_request_n && inbound_enable_n)
      else $error("request or enable still low at capture");
   a_vector_io_rise: assert property (rdata_valid && !io_request_n |=> io_request_n)
      else $error("io request not raised after capture");
   a_refresh_no_read: assert property (!refresh_mark_n |-> read_n && store_n)
      else $error("data strobe in refresh");
   a_refresh_with_memory_request_n: assert property ($fell(refresh_mark_n) |-> $fell(memory_request_n))
      else $error("refresh mark without memory request");
   a_halt_holds: assert property (!halt_n && req_ready && !req_valid |=> !halt_n)
      else $error("halt indicator dropped while idle");
   c_read: cover property (rdata_valid && !read_n);
   c_vector: cover property (rdata_valid && !io_request_n);
   c_refresh: cover property ($fell(refresh_mark_n));
   c_halt: cover property ($fell(halt_n));
endmodule
`default_nettype wire

// ==== bench/mbts_bus_partner.sv ====
// memory and peripheral model on the muxed bus
`timescale 1ns/100ps
`default_nettype none
module mbts_bus_partner (
   input wire logic clk,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe_n,
   input wire logic address_strobe_n,
   input wire logic read_n,
   input wire logic io_request_n,
   input wire logic first_cycle_flag_n,
   input wire logic [3:0] stall_len,
   input wire logic [7:0] vector,
   output logic [7:0] ad_in,
   output logic stall_n
);
   logic [7:0] addr_lo = 8'h00;
   int left = 0;
   initial ad_in = 8'h00;
   initial stall_n = 1'b1;
   always @(posedge clk) begin
      if (!address_strobe_n) begin
         addr_lo = ad_out;
         left = stall_len;
      end else if (left > 0) begin
         left = left - 1;
      end
      #1;
      stall_n = (left == 0);
      if (!ad_oe_n) begin
         ad_in = ad_out;
      end else if (!io_request_n && !first_cycle_flag_n) begin
         ad_in = vector;
      end else if (!read_n) begin
         ad_in = addr_lo ^ 8'h5A;
      end else begin
         ad_in = ~ad_in;
      end
   end
endmodule
`default_nettype wire

// ==== bench/muxed_bus_transaction_seq_bench.sv ====
// self-checking bench for the muxed bus sequencer
`timescale 1ns/100ps
`default_nettype none
module muxed_bus_transaction_seq_bench;
   logic clk, rst_n, req_valid, req_write, stall_n, req_ready, rdata_valid, ad_oe_n;
   logic [2:0] req_kind;
   logic [23:0] req_addr, last_addr, r1;
   logic [7:0] req_wdata, ad_in, rdata, ad_out, wd_seen;
   logic [3:0] auto_waits, stall_len;
   logic [15:0] addr_hi;
   logic address_strobe_n, memory_request_n, io_request_n, first_cycle_flag_n, read_n, store_n;
   logic out_enable_n, inbound_enable_n, refresh_mark_n, halt_n;
   logic [4:0] saw;
   int miscompares = 0, checks = 0, n, n_as, n_m1;
   mbts_seq dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_kind(req_kind),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .auto_waits(auto_waits), .stall_n(stall_n), .ad_in(ad_in), .req_ready(req_ready),
      .rdata(rdata), .rdata_valid(rdata_valid), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
      .addr_hi(addr_hi), .address_strobe_n(address_strobe_n),
      .memory_request_n(memory_request_n), .io_request_n(io_request_n),
      .first_cycle_flag_n(first_cycle_flag_n), .read_n(read_n), .store_n(store_n),
      .out_enable_n(out_enable_n), .inbound_enable_n(inbound_enable_n),
      .refresh_mark_n(refresh_mark_n), .halt_n(halt_n));
   mbts_bus_partner mem (.clk(clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
      .address_strobe_n(address_strobe_n), .read_n(read_n), .io_request_n(io_request_n),
      .first_cycle_flag_n(first_cycle_flag_n), .stall_len(stall_len), .vector(8'hC3),
      .ad_in(ad_in), .stall_n(stall_n));
   // ---------------------------------
   // clock, monitor, helpers
   // ---------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (req_valid && req_ready) begin
         saw <= 5'h00;
         n_as <= 0;
         n_m1 <= 0;
      end else begin
         saw <= saw | ~{memory_request_n, read_n, store_n, io_request_n, refresh_mark_n};
         if (!address_strobe_n) begin
            last_addr <= {addr_hi, ad_out};
            n_as <= n_as + 1;
            n_m1 <= n_m1 + int'(!first_cycle_flag_n);
         end
      end
      if (!store_n) wd_seen <= ad_out;
   end
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic txn(input logic [2:0] k, input logic w, input logic [23:0] a,
         input logic [3:0] aw, input logic [3:0] st);
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1 n++;
      end
      stall_len = st;
      req_kind = k;
      req_write = w;
      req_addr = a;
      req_wdata = a[15:8];
      auto_waits = aw;
      req_valid = 1'b1;
      @(posedge clk);
      #1 req_valid = 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (req_ready !== 1'b1 && n < 100);
   endtask
   task automatic results;
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task automatic t_mem;
      txn(3'd0, 1'b0, 24'h123456, 4'd0, 4'd0);
      chk(24'(n), 24'd3);
      chk(last_addr, 24'h123456);
      chk({16'h0, rdata}, 24'h00000C);
      chk({19'h0, saw}, 24'h000018);
      txn(3'd0, 1'b0, 24'h000011, 4'd2, 4'd2);
      chk(24'(n), 24'd5);
      txn(3'd0, 1'b0, 24'h000022, 4'd0, 4'd3);
      chk(24'(n), 24'd6);
      chk({16'h0, rdata}, 24'h000078);
      txn(3'd0, 1'b1, 24'h00A700, 4'd0, 4'd0);
      chk(24'(n), 24'd3);
      chk({16'h0, wd_seen}, 24'h0000A7);
   endtask
   task automatic t_io;
      txn(3'd4, 1'b1, 24'hAB5E01, 4'd0, 4'd0);
      chk(24'(n), 24'd4);
      chk({16'h0, wd_seen}, 24'h00005E);
      txn(3'd4, 1'b0, 24'h0F0F33, 4'd0, 4'd0);
      chk(24'(n), 24'd4);
      chk(last_addr, 24'h0F0F33);
      chk({16'h0, rdata}, 24'h000069);
      chk({19'h0, saw}, 24'h00000A);
   endtask
   task automatic t_halt;
      txn(3'd2, 1'b0, 24'h000100, 4'd0, 4'd4);
      chk(24'(n), 24'd3);
      chk({19'h0, saw}, 24'h0);
      txn(3'd3, 1'b0, 24'h004321, 4'd0, 4'd4);
      chk(24'(n), 24'd3);
      chk({19'h0, saw}, 24'h000010);
      chk(last_addr, 24'h004321);
      txn(3'd6, 1'b0, 24'h0, 4'd0, 4'd0);
      r1 = last_addr;
      chk({19'h0, saw}, 24'h000011);
      txn(3'd6, 1'b0, 24'h0, 4'd0, 4'd0);
      chk(24'(10'(last_addr[9:0] - r1[9:0])), 24'd1);
      chk({23'h0, halt_n}, 24'h0);
   endtask
   task automatic t_ack;
      txn(3'd5, 1'b0, 24'h0, 4'd0, 4'd0);
      chk(24'(n), 24'd5);
      chk({16'h0, rdata}, 24'h0000C3);
      chk({23'h0, saw[1]}, 24'h1);
      chk({23'h0, halt_n}, 24'h1);
      txn(3'd5, 1'b0, 24'h0, 4'd1, 4'd0);
      chk(24'(n), 24'd6);
      txn(3'h5, 1'b0, 24'h0, 4'h0, 4'h2);
      chk(24'(n), 24'h6);
      chk({23'h0, saw[1]}, 24'h1);
      txn(3'd1, 1'b0, 24'h000040, 4'd0, 4'd0);
      chk(24'(n_as), 24'd2);
      chk(24'(n_m1), 24'd2);
      chk(24'(n), 24'hC);
   endtask
   task automatic t_reset;
      txn(3'h3, 1'b0, 24'h000200, 4'h0, 4'h0);
      chk({23'h0, halt_n}, 24'h0);
      rst_n = 1'b0;
      #1;
      chk({23'h0, halt_n}, 24'h1);
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      txn(3'h0, 1'b0, 24'h000033, 4'h0, 4'h0);
      chk(24'(n), 24'h3);
      chk({16'h0, rdata}, 24'h000069);
   endtask
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_kind = 3'd0;
      req_write = 1'b0;
      req_addr = 24'h0;
      req_wdata = 8'h00;
      auto_waits = 4'd0;
      stall_len = 4'd0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      t_mem();
      t_io();
      t_halt();
      t_ack();
      t_reset();
      results();
   end
   initial begin
      #1_000_000;
      miscompares++;
      results();
   end
endmodule
bind mbts_seq mbts_seq_checker chk_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
   .req_ready(req_ready), .rdata_valid(rdata_valid), .ad_oe_n(ad_oe_n),
   .address_strobe_n(address_strobe_n), .memory_request_n(memory_request_n),
   .io_request_n(io_request_n), .first_cycle_flag_n(first_cycle_flag_n), .read_n(read_n),
   .store_n(store_n), .out_enable_n(out_enable_n), .inbound_enable_n(inbound_enable_n),
   .refresh_mark_n(refresh_mark_n), .halt_n(halt_n));
`default_nettype wire
